/* include/rum_pkg.sv */
// Constants shared by the resource usage monitor register bank
`default_nettype none

package rum_pkg;
    localparam int          DATA_W       = 32;
    localparam int          VAL_W        = 31;
    localparam int          NOT_READY_FLAG_BIT     = 31;
    localparam int          OFF_W        = 12;
    localparam int          MONITOR_INDEX_FIELD_W    = 16;
    localparam int          RIS_W        = 4;
    localparam int          SPACE_N      = 4;
    localparam int          GRP_W        = 32;
    localparam logic [15:0] GRP_MASK     = 16'hffe0;
    localparam logic [11:0] OFF_CAPTURE  = 12'h848;
    localparam logic [11:0] OFF_OVF_MAP  = 12'h858;
    localparam logic [11:0] OFF_BW_USAGE = 12'h860;
    localparam logic [1:0]  SPACE_SEC    = 2'h0;
    localparam logic [1:0]  SPACE_NSEC   = 2'h1;
    localparam logic [1:0]  SPACE_ROOT   = 2'h2;
    localparam logic [1:0]  SPACE_REALM  = 2'h3;
    localparam logic [31:0] CAP_RST      = 32'h0000_0000;
    localparam logic [31:0] RDATA_RST    = 32'h0000_0000;
endpackage : rum_pkg

`default_nettype wire

/* verilog/rum_bw_cell.sv */
// One bandwidth usage counter with its not-ready flag
`timescale 1ns/10ps
`default_nettype none

module rum_bw_cell
    import rum_pkg::*;
#(
    parameter int CNT_W   = 40,
    parameter int BYTES_W = 16
) (
    input  wire logic               core_clk,  // Core clock
    input  wire logic               arst_n,    // Async reset
    input  wire logic               add_en,    // Qualified traffic beat
    input  wire logic [BYTES_W-1:0] add_bytes, // Bytes in the beat
    input  wire logic               not_ready_flag_set,  // Monitor lost accuracy
    input  wire logic               load_en,   // Software write
    input  wire logic [DATA_W-1:0]  load_val,  // Written word
    output logic      [CNT_W-1:0]   count_r,   // Unscaled byte count
    output logic                    not_ready_flag_r     // Not-ready flag
);
    // Wider than the visible field so scaling keeps headroom
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_r <= '0;
            not_ready_flag_r  <= 1'b0;
        end else if (load_en) begin
            count_r <= CNT_W'(load_val[VAL_W-1:0]);
            not_ready_flag_r  <= load_val[NOT_READY_FLAG_BIT] | not_ready_flag_set;
        end else begin
            if (add_en)
                count_r <= count_r + CNT_W'(add_bytes);
            if (not_ready_flag_set)
                not_ready_flag_r <= 1'b1;
        end
    end
endmodule : rum_bw_cell

`default_nettype wire

/* verilog/rum_scale.sv */
// Scaled, rounded view of a bandwidth byte count
`timescale 1ns/10ps
`default_nettype none

module rum_scale
    import rum_pkg::*;
#(
    parameter int CNT_W = 40,
    parameter int SCALE = 4
) (
    input  wire logic [CNT_W-1:0] count,    // Raw byte count
    input  wire logic             scale_en, // Scaling enabled
    output logic      [VAL_W-1:0] value     // Visible field
);
    localparam logic [CNT_W:0] HALF = (CNT_W+1)'((1 << SCALE) >> 1);

    wire [CNT_W:0] rounded = {1'b0, count} + HALF;
    wire [CNT_W:0] shifted = rounded >> SCALE;
    // Saturate rather than wrap once scaled value leaves the field
    wire           over    = |shifted[CNT_W:VAL_W];

    assign value = !scale_en ? count[VAL_W-1:0] :
                   over      ? {VAL_W{1'b1}}    : shifted[VAL_W-1:0];
endmodule : rum_scale

`default_nettype wire

/* verilog/rum_regs.sv */
// Usage monitor register bank: captured storage, overflow map, bandwidth
`timescale 1ns/10ps
`default_nettype none

module rum_regs
    import rum_pkg::*;
#(
    parameter int MON_N    = 8,
    parameter int RIS_N    = 2,
    parameter bit INSTANCE_SELECT_PRESENT  = 1'b1,
    parameter bit HAS_OVF  = 1'b1,
    parameter bit HAS_RLM  = 1'b1,
    parameter int SCALE    = 4,
    parameter int CNT_W    = 40,
    parameter int BYTES_W  = 16,
    parameter int ENT      = SPACE_N * RIS_N * MON_N,
    parameter int ENT_W    = $clog2(ENT)
) (
    input  wire logic                         core_clk,     // Core clock
    input  wire logic                         arst_n,       // Async reset
    input  wire logic                         acc_req,      // Register access
    input  wire logic                         acc_wr,       // 1 write, 0 read
    input  wire logic [1:0]                   acc_space,    // Page of access
    input  wire logic [OFF_W-1:0]             acc_offset,   // Frame offset
    input  wire logic [DATA_W-1:0]            acc_wdata,    // Write data
    output logic      [DATA_W-1:0]            acc_rdata_r,  // Read data
    output logic                              acc_done_r,   // Access done
    input  wire logic [SPACE_N*MONITOR_INDEX_FIELD_W-1:0] monitor_index_field_flat, // Index per space
    input  wire logic [SPACE_N*RIS_W-1:0]     ris_sel_flat, // Resource per space
    input  wire logic [SPACE_N-1:0]           scale_en,     // Scaling per space
    input  wire logic                         cap_valid,    // Capture event
    input  wire logic [ENT_W-1:0]             cap_ent,      // Captured entry
    input  wire logic                         cap_not_ready_flag,     // Capture not ready
    input  wire logic [VAL_W-1:0]             cap_bytes,    // Captured usage
    input  wire logic                         bw_valid,     // Traffic beat
    input  wire logic [ENT_W-1:0]             bw_ent,       // Beat entry
    input  wire logic [BYTES_W-1:0]           bw_bytes,     // Beat size
    input  wire logic                         bw_not_ready_flag,      // Beat not ready
    input  wire logic                         ovf_set,      // Overflow raised
    input  wire logic [ENT_W-1:0]             ovf_set_ent,  // Raised entry
    input  wire logic                         ovf_clr,      // Overflow cleared
    input  wire logic [ENT_W-1:0]             ovf_clr_ent   // Cleared entry
);
    function automatic logic [ENT_W-1:0] ent_of(
        input logic [1:0]       sp,
        input logic [RIS_W-1:0] ri,
        input logic [31:0]      mo
    );
        logic [31:0] full;
        full = (32'(sp) * 32'(RIS_N) + 32'(ri)) * 32'(MON_N) + mo;
        return full[ENT_W-1:0];
    endfunction : ent_of

    logic [DATA_W-1:0] cap_val_r [ENT];
    logic [ENT-1:0]    ovf_r;
    logic [ENT-1:0]    ovf_nxt;
    logic [CNT_W-1:0]  cnt_a [ENT];
    logic [ENT-1:0]    bw_not_ready_flag_a;
    logic [GRP_W-1:0]  grp_bits;
    logic [VAL_W-1:0]  bw_view;
    logic [DATA_W-1:0] rdata_nxt;

    // Selection of the page's own index registers only
    wire [MONITOR_INDEX_FIELD_W-1:0] mon_q   = monitor_index_field_flat[acc_space*MONITOR_INDEX_FIELD_W +: MONITOR_INDEX_FIELD_W];
    wire [RIS_W-1:0]     ris_raw = ris_sel_flat[acc_space*RIS_W +: RIS_W];
    wire [RIS_W-1:0]     ris_q   = INSTANCE_SELECT_PRESENT ? ris_raw : '0;
    wire                 ris_ok  = 32'(ris_q) < 32'(RIS_N);
    wire                 mon_ok  = ris_ok && (32'(mon_q) < 32'(MON_N));
    wire [ENT_W-1:0]     ent     = ent_of(acc_space, ris_q, 32'(mon_q));

    // Root and realm pages exist only with the realm extension
    wire space_ok = HAS_RLM || (acc_space == SPACE_SEC) || (acc_space == SPACE_NSEC);
    wire acc_ok   = acc_req && space_ok;
    wire hit_cap  = acc_ok && (acc_offset == OFF_CAPTURE);
    wire hit_ovf  = acc_ok && HAS_OVF && (acc_offset == OFF_OVF_MAP);
    wire hit_bw   = acc_ok && (acc_offset == OFF_BW_USAGE);
    wire wr_cap   = hit_cap && acc_wr && mon_ok;
    wire wr_bw    = hit_bw && acc_wr && mon_ok;

    // Group of 32 starting at the masked index
    wire [MONITOR_INDEX_FIELD_W-1:0] grp_base = mon_q & GRP_MASK;

    // A scanning handler steps the index by 32 per group
    for (genvar i = 0; i < GRP_W; i++) begin : g_grp
        wire [31:0] m_w = 32'(grp_base) + 32'(i);
        wire        in_w = ris_ok && (m_w < 32'(MON_N));
        assign grp_bits[i] = in_w && ovf_r[ent_of(acc_space, ris_q, m_w)];
    end

    for (genvar e = 0; e < ENT; e++) begin : g_bw
        rum_bw_cell #(
            .CNT_W   (CNT_W),
            .BYTES_W (BYTES_W)
        ) u_cell (
            .core_clk  (core_clk),
            .arst_n    (arst_n),
            .add_en    (bw_valid && (bw_ent == ENT_W'(e))),
            .add_bytes (bw_bytes),
            .not_ready_flag_set  (bw_valid && bw_not_ready_flag && (bw_ent == ENT_W'(e))),
            .load_en   (wr_bw && (ent == ENT_W'(e))),
            .load_val  (acc_wdata),
            .count_r   (cnt_a[e]),
            .not_ready_flag_r    (bw_not_ready_flag_a[e])
        );
    end

    rum_scale #(
        .CNT_W (CNT_W),
        .SCALE (SCALE)
    ) u_scale (
        .count    (cnt_a[ent]),
        .scale_en (scale_en[acc_space]),
        .value    (bw_view)
    );

    // Set wins over clear in the same cycle
    wire [ENT-1:0] set_mask = ovf_set ? (ENT'(1) << ovf_set_ent) : '0;
    wire [ENT-1:0] clr_mask = ovf_clr ? (ENT'(1) << ovf_clr_ent) : '0;
    assign ovf_nxt = (ovf_r & ~clr_mask) | set_mask;

    wire [DATA_W-1:0] cap_rd = mon_ok ? cap_val_r[ent] : '0;
    wire [DATA_W-1:0] bw_rd  = mon_ok ? {bw_not_ready_flag_a[ent], bw_view} : '0;

    // Writes and unmapped offsets read back zero
    assign rdata_nxt = (!acc_ok || acc_wr) ? RDATA_RST :
                       hit_cap             ? cap_rd    :
                       hit_ovf             ? grp_bits  :
                       hit_bw              ? bw_rd     : RDATA_RST;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int k = 0; k < ENT; k++)
                cap_val_r[k] <= CAP_RST;
        end else begin
            if (cap_valid)
                cap_val_r[cap_ent] <= {cap_not_ready_flag, cap_bytes};
            // Software write last so it overrides a same-entry capture
            if (wr_cap)
                cap_val_r[ent] <= acc_wdata;
        end
    end

    // Bitmap is read-only: only monitor events move it
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n)
            ovf_r <= '0;
        else
            ovf_r <= ovf_nxt;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_rdata_r <= RDATA_RST;
            acc_done_r  <= 1'b0;
        end else begin
            acc_rdata_r <= rdata_nxt;
            acc_done_r  <= acc_req;
        end
    end

    // Helpers seen only by the checks below
    wire [DATA_W-1:0] cap_at_ev = cap_val_r[cap_ent];
    wire [CNT_W-1:0]  cnt_at_ev = cnt_a[bw_ent];
    wire              wr_hits_bw_ev = wr_bw && (ent == bw_ent);
    wire              wr_hits_cap_ev = wr_cap && (ent == cap_ent);

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    property p_done_one;
        acc_req |=> acc_done_r ##1 (acc_done_r == $past(acc_req));
    endproperty
    a_done_one: assert property (p_done_one) else $error("done not one cycle after request");

    property p_cap_store;
        cap_valid && !wr_hits_cap_ev |=>
            cap_val_r[$past(cap_ent)] == {$past(cap_not_ready_flag), $past(cap_bytes)};
    endproperty
    a_cap_store: assert property (p_cap_store) else $error("capture not stored with flag");

    property p_cap_read;
        hit_cap && !acc_wr |=> acc_rdata_r == $past(cap_rd);
    endproperty
    a_cap_read: assert property (p_cap_read) else $error("captured read mismatch");

    property p_page_gate;
        acc_req && !space_ok |=> acc_done_r && (acc_rdata_r == '0);
    endproperty
    a_page_gate: assert property (p_page_gate) else $error("absent page returned data");

    property p_ovf_absent;
        acc_req && !HAS_OVF && (acc_offset == OFF_OVF_MAP) |=> acc_rdata_r == '0;
    endproperty
    a_ovf_absent: assert property (p_ovf_absent) else $error("absent bitmap not zero");

    property p_ovf_ro;
        hit_ovf && acc_wr && !ovf_set && !ovf_clr |=> $stable(ovf_r);
    endproperty
    a_ovf_ro: assert property (p_ovf_ro) else $error("bitmap changed by write");

    property p_ovf_sticky;
        ovf_set |=> ovf_r[$past(ovf_set_ent)] ##1
            (ovf_r[$past(ovf_set_ent, 2)] || $past(ovf_clr));
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow bit lost");

    property p_ovf_map;
        hit_ovf && !acc_wr && ris_ok && (32'(grp_base) < 32'(MON_N)) |=>
            acc_rdata_r[0] == $past(ovf_r[ent_of(acc_space, ris_q, 32'(grp_base))]);
    endproperty
    a_ovf_map: assert property (p_ovf_map) else $error("bitmap bit 0 wrong monitor");

    property p_bw_flag;
        hit_bw && !acc_wr && mon_ok |=> acc_rdata_r[NOT_READY_FLAG_BIT] == $past(bw_not_ready_flag_a[ent]);
    endproperty
    a_bw_flag: assert property (p_bw_flag) else $error("bandwidth flag mismatch");

    property p_bw_count;
        bw_valid && !wr_hits_bw_ev |=>
            cnt_a[$past(bw_ent)] == $past(cnt_at_ev) + CNT_W'($past(bw_bytes));
    endproperty
    a_bw_count: assert property (p_bw_count) else $error("bandwidth count not added");

    c_cap_rd: cover property (cap_valid ##1 hit_cap && !acc_wr);
    c_ovf_rd: cover property (ovf_set ##1 hit_ovf && !acc_wr);
    c_bw_scl: cover property (hit_bw && !acc_wr && scale_en[acc_space]);
    c_set_clr: cover property (ovf_set && ovf_clr && (ovf_set_ent == ovf_clr_ent));
endmodule : rum_regs

`default_nettype wire

/* verif/rum_regs_tb.sv */
// Self-checking bench for the usage monitor register bank
`timescale 1ns/10ps
`default_nettype none

module rum_regs_tb;
    import rum_pkg::*;
    localparam int MON_N = 8;
    localparam int RIS_N = 2;
    localparam int SCALE = 4;
    localparam int ENT   = SPACE_N * RIS_N * MON_N;

    logic                         core_clk;
    logic                         arst_n;
    logic                         acc_req;
    logic                         acc_wr;
    logic [1:0]                   acc_space;
    logic [OFF_W-1:0]             acc_offset;
    logic [DATA_W-1:0]            acc_wdata;
    logic [DATA_W-1:0]            acc_rdata_r;
    logic                         acc_done_r;
    logic [SPACE_N*MONITOR_INDEX_FIELD_W-1:0] monitor_index_field_flat;
    logic [SPACE_N*RIS_W-1:0]     ris_sel_flat;
    logic [SPACE_N-1:0]           scale_en;
    logic                         cap_valid, cap_not_ready_flag, bw_valid, bw_not_ready_flag, ovf_set, ovf_clr;
    logic [5:0]                   cap_ent, bw_ent, ovf_set_ent, ovf_clr_ent;
    logic [VAL_W-1:0]             cap_bytes;
    logic [15:0]                  bw_bytes;
    logic [15:0]                  lfsr_r;
    logic [31:0]                  cap_m [ENT];
    longint                       cnt_m [ENT];
    bit                           not_ready_flag_m [ENT];
    bit                           ovf_m [ENT];
    int                           n_errors;
    int                           tests_run;
    logic [11:0]                  offs [4] = '{12'h848, 12'h858, 12'h860, 12'h850};

    rum_regs #(.MON_N(MON_N), .RIS_N(RIS_N), .SCALE(SCALE)) u_rum_regs (
        .core_clk(core_clk), .arst_n(arst_n), .acc_req(acc_req), .acc_wr(acc_wr),
        .acc_space(acc_space), .acc_offset(acc_offset), .acc_wdata(acc_wdata),
        .acc_rdata_r(acc_rdata_r), .acc_done_r(acc_done_r), .monitor_index_field_flat(monitor_index_field_flat),
        .ris_sel_flat(ris_sel_flat), .scale_en(scale_en), .cap_valid(cap_valid), .cap_ent(cap_ent),
        .cap_not_ready_flag(cap_not_ready_flag), .cap_bytes(cap_bytes), .bw_valid(bw_valid), .bw_ent(bw_ent),
        .bw_bytes(bw_bytes), .bw_not_ready_flag(bw_not_ready_flag), .ovf_set(ovf_set), .ovf_set_ent(ovf_set_ent),
        .ovf_clr(ovf_clr), .ovf_clr_ent(ovf_clr_ent));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    function logic [15:0] rnd();
        lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
        return lfsr_r;
    endfunction : rnd

    // Entry picked by a page's own selects, or -1 when out of range
    function automatic int ent_of(int s);
        int m, r;
        m = int'(monitor_index_field_flat[16*s +: 16]);
        r = int'(ris_sel_flat[4*s +: 4]);
        return (m < MON_N && r < RIS_N) ? (s * RIS_N + r) * MON_N + m : -1;
    endfunction : ent_of

    function automatic logic [31:0] model_rd(int s, logic [11:0] off);
        int e, b;
        longint sc;
        logic [31:0] v;
        e = ent_of(s);
        v = 32'h0;
        if (e >= 0) begin
            b = e - e % MON_N;
            sc = (cnt_m[e] + (64'h1 << (SCALE - 1))) >> SCALE;
            if (sc > 64'h7fff_ffff) sc = 64'h7fff_ffff;
            if (off == 12'h848) v = cap_m[e];
            if (off == 12'h860) v = {not_ready_flag_m[e], scale_en[s] ? sc[30:0] : cnt_m[e][30:0]};
            if (off == 12'h858) begin
                for (int i = 0; i < MON_N; i++) v[i] = ovf_m[b + i];
            end
        end
        return v;
    endfunction : model_rd

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic acc(input logic wr, input int s, input logic [11:0] off, input logic [31:0] wd);
        logic [31:0] exp;
        int e;
        exp = wr ? 32'h0 : model_rd(s, off);
        e = ent_of(s);
        @(posedge core_clk);
        acc_req    <= 1'b1;
        acc_wr     <= wr;
        acc_space  <= s[1:0];
        acc_offset <= off;
        acc_wdata  <= wd;
        @(posedge core_clk);
        acc_req <= 1'b0;
        #1;
        chk({31'h0, acc_done_r}, 32'h1);
        chk(acc_rdata_r, exp);
        if (wr && e >= 0 && off == 12'h848) cap_m[e] = wd;
        if (wr && e >= 0 && off == 12'h860) begin
            cnt_m[e]  = longint'(wd[30:0]);
            not_ready_flag_m[e] = wd[31];
        end
    endtask : acc

    task automatic ev(input int k, input int e, input logic [31:0] v);
        @(posedge core_clk);
        case (k)
            0: begin
                cap_valid <= 1'b1; cap_ent <= e[5:0]; cap_not_ready_flag <= v[31]; cap_bytes <= v[30:0];
                cap_m[e] = v;
            end
            1: begin
                bw_valid <= 1'b1; bw_ent <= e[5:0]; bw_bytes <= v[15:0]; bw_not_ready_flag <= v[31];
                cnt_m[e] += longint'(v[15:0]);
                not_ready_flag_m[e] |= v[31];
            end
            2: begin ovf_set <= 1'b1; ovf_set_ent <= e[5:0]; ovf_m[e] = 1'b1; end
            default: begin ovf_clr <= 1'b1; ovf_clr_ent <= e[5:0]; ovf_m[e] = 1'b0; end
        endcase
        @(posedge core_clk);
        {cap_valid, bw_valid, ovf_set, ovf_clr} <= 4'h0;
    endtask : ev

    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    initial begin
        #400000;
        n_errors++;
        print_verdict();
    end

    initial begin
        int s, e;
        {arst_n, acc_req, acc_wr, acc_space, acc_offset, acc_wdata} = '0;
        {monitor_index_field_flat, ris_sel_flat, scale_en} = '0;
        {cap_valid, cap_not_ready_flag, cap_bytes, cap_ent, bw_valid, bw_ent, bw_bytes, bw_not_ready_flag} = '0;
        {ovf_set, ovf_set_ent, ovf_clr, ovf_clr_ent} = '0;
        lfsr_r = 16'hfae5;
        n_errors = 0;
        tests_run = 0;
        foreach (cap_m[i]) begin
            cap_m[i] = 32'h0; cnt_m[i] = 0; not_ready_flag_m[i] = 1'b0; ovf_m[i] = 1'b0;
        end
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        for (int j = 0; j < 16; j++) acc(1'b0, j / 4, offs[j % 4], 32'h0);
        // Rounding boundary around half a scaled unit
        scale_en <= 4'h1;
        foreach (offs[j]) begin
            acc(1'b1, 0, 12'h860, 32'h7 + 32'h1 * j);
            acc(1'b0, 0, 12'h860, 32'h0);
        end
        // Handler stepping the index by 32 lands past the last monitor
        monitor_index_field_flat[16 +: 16] <= 16'h20;
        @(posedge core_clk);
        acc(1'b0, 1, 12'h858, 32'h0);
        acc(1'b0, 1, 12'h848, 32'h0);
        monitor_index_field_flat <= '0;
        @(posedge core_clk);
        for (int n = 0; n < 300; n++) begin
            for (int t = 0; t < SPACE_N; t++) begin
                monitor_index_field_flat[16*t +: 16] <= rnd() % 16'h8;
                ris_sel_flat[4*t +: 4]   <= 4'(rnd() % 16'h3);
            end
            scale_en <= rnd();
            s = int'(rnd() % 16'h4);
            @(posedge core_clk);
            e = ent_of(s);
            ev(int'(rnd() % 16'h4), (e >= 0) ? e : int'(rnd() % 16'h40), {rnd(), rnd()});
            foreach (offs[j]) acc(rnd() % 16'h4 == 16'h0, s, offs[j], {rnd(), rnd()});
        end
        print_verdict();
    end
endmodule : rum_regs_tb

`default_nettype wire
